// *** hdl/mmd_pkg.sv ***
// constants for the memory map decoder
package mmd_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned WORD_W = 24;
  localparam logic [23:0] ILLEGAL_OP = 24'h000005;
  localparam logic [15:0] BOOT_LO_BASE = 16'h0000;
  localparam logic [15:0] BOOT_LO_LAST = 16'h001f;
  localparam logic [15:0] BOOT_HI_BASE = 16'h0100;
  localparam logic [15:0] BOOT_HI_LAST = 16'h011f;
  localparam logic [15:0] PRAM_WORDS = 16'h0200;
  localparam logic [15:0] VEC_TOP = 16'h007f;
  localparam logic [15:0] X_RSV_BASE = 16'h2c00;
  localparam logic [15:0] Y_RSV_BASE = 16'h2700;
  localparam logic [15:0] DATA_UNDEF_TOP = 16'h2000;
  localparam logic [15:0] PERIPH_BASE = 16'hffe0;
  localparam logic [15:0] IPR_ADDR = 16'hffff;
  // populated peripheral slots, bit n = X:ffe0+n
  localparam logic [31:0] PERIPH_USED = 32'ha0cf_ffff;
  localparam int unsigned BOOT_LOAD_MAX = 512;
endpackage

// *** hdl/mmd_port_if.sv ***
// one address port of the decoder: request in, decode out
`timescale 1ns/1ps
interface mmd_port_if;
  logic [15:0] addr;
  logic rd;
  logic wr;
  logic sel_ram;
  logic sel_rom;
  logic sel_periph;
  logic [4:0] periph_slot;
  logic rsv;
  logic wr_ok;
  logic rd_ok;
  modport dec(input addr, rd, wr, output sel_ram, sel_rom, sel_periph, periph_slot, rsv, wr_ok, rd_ok);
  modport top(output addr, rd, wr, input sel_ram, sel_rom, sel_periph, periph_slot, rsv, wr_ok, rd_ok);
endinterface

// *** hdl/mmd_space_dec.sv ***
// combinational decode of one memory space
`timescale 1ns/1ps
module mmd_space_dec #(
  parameter logic [1:0] SPACE = 2'h0,
  parameter logic [15:0] RAM_TOP = 16'h01ff,
  parameter logic [15:0] RSV_BASE = 16'h0200
) (
  mmd_port_if.dec p,
  input wire logic boot_in
);
  logic in_rom;
  logic in_periph;
  logic slot_used;
  always_comb begin
    in_rom = (SPACE == 2'h0) &&
      ((p.addr <= mmd_pkg::BOOT_LO_LAST) ||
       (p.addr >= mmd_pkg::BOOT_HI_BASE && p.addr <= mmd_pkg::BOOT_HI_LAST));
    in_periph = (SPACE == 2'h1) && (p.addr >= mmd_pkg::PERIPH_BASE);
    slot_used = mmd_pkg::PERIPH_USED[p.addr[4:0]];
    p.periph_slot = p.addr[4:0];
    p.sel_rom = in_rom && boot_in;
    p.sel_periph = in_periph && slot_used;
    p.sel_ram = !p.sel_rom && !in_periph && (p.addr <= RAM_TOP);
    p.rsv = !p.sel_rom && !p.sel_ram && !p.sel_periph;
    p.wr_ok = p.wr && !p.rsv && !p.sel_rom;
    // in bootstrap the low program ram is write-only
    p.rd_ok = p.rd && !p.rsv && !(SPACE == 2'h0 && boot_in && p.sel_ram
      && p.addr < mmd_pkg::PRAM_WORDS);
  end
endmodule

// *** hdl/mmd_top.sv ***
// memory map decoder for program, x and y spaces
`timescale 1ns/1ps
// Function
// - bootstrap rom answers at program words 0-31 and 256-287.
// - after reset, boot either branches to user start or loads up to 512 words.
// - three mode-select bits of the operating mode register pick the boot behaviour.
// - in bootstrap, reads of low 512 program ram words blocked, writes still land outside the rom windows.
// - program ram holds 512 words, no program rom.
// - writes to reserved addresses in any space are discarded.
// - reserved reads at x>=2c00, y>=2700 or reserved program return 000005.
// - reserved x/y reads below 2000 return undefined data.
// - fetch from a reserved address delivers opcode 000005.
// - peripheral registers decoded at x ffe0-ffff, priority register at top.
// - all three spaces carry 24-bit words.
// - lowest 128 program words hold the interrupt vector table.
module mmd_top #(
  parameter int unsigned X_RAM_WORDS = 256,
  parameter int unsigned Y_RAM_WORDS = 256,
  parameter int unsigned P_RAM_WORDS = 512
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [15:0] pab_in,
  input wire logic p_fetch_in,
  input wire logic p_rd_in,
  input wire logic p_wr_in,
  input wire logic [23:0] p_wdata_in,
  input wire logic [15:0] xab_in,
  input wire logic x_rd_in,
  input wire logic x_wr_in,
  input wire logic [23:0] x_wdata_in,
  input wire logic [15:0] yab_in,
  input wire logic y_rd_in,
  input wire logic y_wr_in,
  input wire logic [23:0] y_wdata_in,
  input wire logic [2:0] boot_mode_sel_in,
  input wire logic boot_done_in,
  input wire logic [23:0] boot_rom_data_in,
  input wire logic [23:0] periph_rdata_in,
  output logic [23:0] p_rdata_out,
  output logic [23:0] x_rdata_out,
  output logic [23:0] y_rdata_out,
  output logic boot_mode_out,
  output logic [2:0] boot_action_out,
  output logic [15:0] boot_rom_addr_out,
  output logic periph_rd_out,
  output logic periph_wr_out,
  output logic [4:0] periph_slot_out,
  output logic [23:0] periph_wdata_out,
  output logic vec_fetch_out,
  output logic illegal_fetch_out
);
  if (P_RAM_WORDS != 512 || X_RAM_WORDS < 1 || X_RAM_WORDS > 8192
      || Y_RAM_WORDS < 1 || Y_RAM_WORDS > 8192) begin : g_bad_size
    $error("mmd_top: unsupported memory size");
  end
  localparam logic [15:0] X_TOP = 16'(X_RAM_WORDS - 1);
  localparam logic [15:0] Y_TOP = 16'(Y_RAM_WORDS - 1);
  localparam logic [15:0] P_TOP = 16'(P_RAM_WORDS - 1);

  mmd_port_if pp();
  mmd_port_if xp();
  mmd_port_if yp();
  assign pp.addr = pab_in;
  assign pp.rd = p_rd_in | p_fetch_in;
  assign pp.wr = p_wr_in;
  assign xp.addr = xab_in;
  assign xp.rd = x_rd_in;
  assign xp.wr = x_wr_in;
  assign yp.addr = yab_in;
  assign yp.rd = y_rd_in;
  assign yp.wr = y_wr_in;

  typedef struct packed {
    logic run;
    logic boot;
    logic [2:0] action;
    logic [23:0] p_rdata;
    logic [23:0] x_rdata;
    logic [23:0] y_rdata;
    logic [23:0] p_rdata_q;
    logic [23:0] x_rdata_q;
    logic [23:0] y_rdata_q;
    logic [15:0] rom_addr;
    logic periph_rd;
    logic periph_wr;
    logic [4:0] slot;
    logic [23:0] periph_wdata;
    logic vec_fetch;
    logic ill_fetch;
    logic p_rom_pend;
    logic x_per_pend;
    logic p_ram_hit;
    logic x_ram_hit;
    logic y_ram_hit;
  } mmd_state_t;
  mmd_state_t s_r;
  mmd_state_t s_nxt;

  // storage, 24 bits wide in every space
  logic [23:0] pram [P_RAM_WORDS];
  logic [23:0] xram [X_RAM_WORDS];
  logic [23:0] yram [Y_RAM_WORDS];
  logic [23:0] p_ram_q;
  logic [23:0] x_ram_q;
  logic [23:0] y_ram_q;

  mmd_space_dec #(.SPACE(2'h0), .RAM_TOP(P_TOP), .RSV_BASE(16'h0200)) u_pdec (.p(pp), .boot_in(s_r.boot));
  mmd_space_dec #(.SPACE(2'h1), .RAM_TOP(X_TOP), .RSV_BASE(mmd_pkg::X_RSV_BASE)) u_xdec (.p(xp), .boot_in(1'b0));
  mmd_space_dec #(.SPACE(2'h2), .RAM_TOP(Y_TOP), .RSV_BASE(mmd_pkg::Y_RSV_BASE)) u_ydec (.p(yp), .boot_in(1'b0));

  always_ff @(posedge clk_in) begin
    if (pp.wr_ok && pp.sel_ram)
      pram[pab_in[8:0]] <= p_wdata_in;
    if (xp.wr_ok && xp.sel_ram)
      xram[xab_in[12:0] % X_RAM_WORDS] <= x_wdata_in;
    if (yp.wr_ok && yp.sel_ram)
      yram[yab_in[12:0] % Y_RAM_WORDS] <= y_wdata_in;
    p_ram_q <= pram[pab_in[8:0]];
    x_ram_q <= xram[xab_in[12:0] % X_RAM_WORDS];
    y_ram_q <= yram[yab_in[12:0] % Y_RAM_WORDS];
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.run = 1'b1;
    // mode bits are caught on the first edge after reset release
    if (!s_r.run) begin
      s_nxt.boot = 1'b1;
      s_nxt.action = boot_mode_sel_in;
    end else if (boot_done_in) begin
      s_nxt.boot = 1'b0;
    end
    s_nxt.rom_addr = pab_in;
    s_nxt.p_rom_pend = pp.rd && pp.sel_rom;
    s_nxt.vec_fetch = p_fetch_in && (pab_in <= mmd_pkg::VEC_TOP);
    s_nxt.ill_fetch = p_fetch_in && pp.rsv;
    s_nxt.periph_rd = xp.rd_ok && xp.sel_periph;
    s_nxt.periph_wr = xp.wr_ok && xp.sel_periph;
    s_nxt.slot = xp.periph_slot;
    s_nxt.periph_wdata = x_wdata_in;
    s_nxt.x_per_pend = xp.rd_ok && xp.sel_periph;
    // first stage: fallback data for every address, 000005 where a reserved or blocked read returns it
    s_nxt.p_rdata = (pp.rsv || !pp.rd_ok) ? mmd_pkg::ILLEGAL_OP : 24'h000000;
    s_nxt.x_rdata = (xp.rsv && xab_in >= mmd_pkg::X_RSV_BASE) ? mmd_pkg::ILLEGAL_OP : 24'h000000;
    s_nxt.y_rdata = (yp.rsv && yab_in >= mmd_pkg::Y_RSV_BASE) ? mmd_pkg::ILLEGAL_OP : 24'h000000;
    s_nxt.p_ram_hit = pp.rd_ok && pp.sel_ram;
    s_nxt.x_ram_hit = xp.rd_ok && xp.sel_ram;
    s_nxt.y_ram_hit = yp.rd_ok && yp.sel_ram;
    // second stage: read data leaves a flop two edges after the strobe
    s_nxt.p_rdata_q = s_r.p_rom_pend ? boot_rom_data_in : (s_r.p_ram_hit ? p_ram_q : s_r.p_rdata);
    s_nxt.x_rdata_q = s_r.x_per_pend ? periph_rdata_in : (s_r.x_ram_hit ? x_ram_q : s_r.x_rdata);
    s_nxt.y_rdata_q = s_r.y_ram_hit ? y_ram_q : s_r.y_rdata;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign p_rdata_out = s_r.p_rdata_q;
  assign x_rdata_out = s_r.x_rdata_q;
  assign y_rdata_out = s_r.y_rdata_q;
  assign boot_mode_out = s_r.boot;
  assign boot_action_out = s_r.action;
  assign boot_rom_addr_out = s_r.rom_addr;
  assign periph_rd_out = s_r.periph_rd;
  assign periph_wr_out = s_r.periph_wr;
  assign periph_slot_out = s_r.slot;
  assign periph_wdata_out = s_r.periph_wdata;
  assign vec_fetch_out = s_r.vec_fetch;
  assign illegal_fetch_out = s_r.ill_fetch;

  a_rsv_fetch_op: assert property (@(posedge clk_in) disable iff (rst_in)
    (p_fetch_in && pp.rsv) |=> (illegal_fetch_out ##1 p_rdata_out == 24'h000005))
    else $error("reserved fetch did not return illegal opcode");
  a_x_rsv_read: assert property (@(posedge clk_in) disable iff (rst_in)
    (x_rd_in && xab_in >= 16'h2c00 && xab_in < 16'hffe0) |=> ##1 x_rdata_out == 24'h000005)
    else $error("reserved x read wrong");
  a_y_rsv_read: assert property (@(posedge clk_in) disable iff (rst_in)
    (y_rd_in && yab_in >= 16'h2700) |=> ##1 y_rdata_out == 24'h000005)
    else $error("reserved y read wrong");
  a_boot_rd_block: assert property (@(posedge clk_in) disable iff (rst_in)
    (boot_mode_out && p_rd_in && ((pab_in >= 16'h0020 && pab_in < 16'h0100) || (pab_in >= 16'h0120 && pab_in < 16'h0200)))
      |=> ##1 p_rdata_out == 24'h000005)
    else $error("boot-mode ram read not blocked");
  a_rsv_no_write: assert property (@(posedge clk_in) disable iff (rst_in)
    (x_wr_in && xab_in >= 16'h2c00 && xab_in < 16'hffe0) |=> !periph_wr_out)
    else $error("reserved write leaked");
  a_periph_slot: assert property (@(posedge clk_in) disable iff (rst_in)
    (x_wr_in && xab_in == 16'hffff) |=> (periph_wr_out && periph_slot_out == 5'h1f))
    else $error("priority register write missed");
  a_periph_rsv: assert property (@(posedge clk_in) disable iff (rst_in)
    (x_wr_in && xab_in == 16'hfffe) |=> !periph_wr_out)
    else $error("reserved peripheral slot written");
  a_mode_latch: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(s_r.run) |-> (boot_mode_out && boot_action_out == $past(boot_mode_sel_in)))
    else $error("mode bits not captured");
  a_vec_fetch: assert property (@(posedge clk_in) disable iff (rst_in)
    (p_fetch_in && pab_in < 16'h0080) |=> vec_fetch_out)
    else $error("vector fetch not flagged");
  a_vec_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    (p_fetch_in && pab_in >= 16'h0080) |=> !vec_fetch_out)
    else $error("vector fetch flagged outside table");
  a_boot_rom_wr: assert property (@(posedge clk_in) disable iff (rst_in)
    (boot_mode_out && p_wr_in && (pab_in <= 16'h001f || (pab_in >= 16'h0100 && pab_in <= 16'h011f))) |-> !pp.wr_ok)
    else $error("bootstrap rom window written");
  a_boot_ram_wr: assert property (@(posedge clk_in) disable iff (rst_in)
    (boot_mode_out && p_wr_in && pab_in >= 16'h0120 && pab_in <= 16'h01ff) |-> (pp.wr_ok && pp.sel_ram))
    else $error("bootstrap ram write dropped");
  a_rom_read: assert property (@(posedge clk_in) disable iff (rst_in)
    (boot_mode_out && (p_rd_in || p_fetch_in) && (pab_in <= 16'h001f || (pab_in >= 16'h0100 && pab_in <= 16'h011f)))
      |=> ##1 p_rdata_out == $past(boot_rom_data_in))
    else $error("bootstrap rom read wrong");
  a_periph_read: assert property (@(posedge clk_in) disable iff (rst_in)
    (x_rd_in && xab_in == 16'hffff) |=> (periph_rd_out && periph_slot_out == 5'h1f))
    else $error("priority register read missed");
  a_rsv_no_read: assert property (@(posedge clk_in) disable iff (rst_in)
    (x_rd_in && xab_in >= 16'h2c00 && xab_in < 16'hffe0) |=> !periph_rd_out)
    else $error("reserved read reached a peripheral");
endmodule

// *** test/mmd_core_model.sv ***
// far-side model: bootstrap rom data built from the address, and peripheral register read data
`timescale 1ns/1ps
module mmd_core_model (
  input wire logic [15:0] boot_rom_addr_in,
  input wire logic periph_rd_in,
  input wire logic [4:0] periph_slot_in,
  output logic [23:0] rom_data_out,
  output logic [23:0] periph_rdata_out
);
  logic [23:0] pdata;
  // rom word carries its own low address bits so a misplaced window shows
  assign rom_data_out = {16'h3c3c, 3'h0, boot_rom_addr_in[4:0]};
  assign pdata = {16'h5aa5, 3'h0, periph_slot_in};
  // released bus shows the inverse, never the last value
  assign periph_rdata_out = periph_rd_in ? pdata : ~pdata;
endmodule

// *** test/tb.sv ***
// self-checking testbench for the memory map decoder
`timescale 1ns/1ps
module tb;
  logic clk_in, rst_in, p_fetch_in, p_rd_in, p_wr_in, x_rd_in, x_wr_in, y_rd_in, y_wr_in, boot_done_in;
  logic [15:0] pab_in, xab_in, yab_in, boot_rom_addr_out;
  logic [23:0] p_wdata_in, x_wdata_in, y_wdata_in, boot_rom_data_in, periph_rdata_in;
  logic [23:0] p_rdata_out, x_rdata_out, y_rdata_out, periph_wdata_out;
  logic [2:0] boot_mode_sel_in, boot_action_out;
  logic boot_mode_out, periph_rd_out, periph_wr_out, vec_fetch_out, illegal_fetch_out;
  logic [4:0] periph_slot_out;
  int failures, check_count;
  mmd_top u_dut (.clk_in, .rst_in, .pab_in, .p_fetch_in, .p_rd_in, .p_wr_in, .p_wdata_in, .xab_in, .x_rd_in,
    .x_wr_in, .x_wdata_in, .yab_in, .y_rd_in, .y_wr_in, .y_wdata_in, .boot_mode_sel_in, .boot_done_in,
    .boot_rom_data_in, .periph_rdata_in, .p_rdata_out, .x_rdata_out, .y_rdata_out, .boot_mode_out,
    .boot_action_out, .boot_rom_addr_out, .periph_rd_out, .periph_wr_out, .periph_slot_out,
    .periph_wdata_out, .vec_fetch_out, .illegal_fetch_out);
  mmd_core_model u_core (.boot_rom_addr_in(boot_rom_addr_out), .periph_rd_in(periph_rd_out),
    .periph_slot_in(periph_slot_out), .rom_data_out(boot_rom_data_in), .periph_rdata_out(periph_rdata_in));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, s, e);
    end
  endtask
  // sp: 0 p fetch, 1 p data, 2 x, 3 y; pulses stand at return, read data one negedge later
  task automatic op(input logic [1:0] sp, input logic [15:0] a, input logic w, input logic [23:0] d);
    @(negedge clk_in);
    {pab_in, xab_in, yab_in} = {a, a, a};
    {p_wdata_in, x_wdata_in, y_wdata_in} = {d, d, d};
    p_fetch_in = sp == 2'h0;
    {p_rd_in, p_wr_in} = {sp == 2'h1 && !w, sp == 2'h1 && w};
    {x_rd_in, x_wr_in} = {sp == 2'h2 && !w, sp == 2'h2 && w};
    {y_rd_in, y_wr_in} = {sp == 2'h3 && !w, sp == 2'h3 && w};
    @(negedge clk_in);
    {p_fetch_in, p_rd_in, p_wr_in, x_rd_in, x_wr_in, y_rd_in, y_wr_in} = 7'h00;
  endtask
  task automatic t_boot;
    op(1, 16'h0010, 0, 0);
    @(negedge clk_in);
    chk(p_rdata_out, 24'h3c3c10);
    op(0, 16'h0105, 0, 0);
    chk(boot_rom_addr_out, 16'h0105);
    @(negedge clk_in);
    chk(p_rdata_out, 24'h3c3c05);
    op(1, 16'h0150, 1, 24'h123456);
    op(1, 16'h0150, 0, 0);
    @(negedge clk_in);
    chk(p_rdata_out, 24'h000005);
    op(1, 16'h0120, 0, 0);
    @(negedge clk_in);
    chk(p_rdata_out, 24'h000005);
    boot_done_in = 1'b1;
    @(negedge clk_in);
    boot_done_in = 1'b0;
    @(negedge clk_in);
    chk(boot_mode_out, 0);
    op(1, 16'h0150, 0, 0);
    @(negedge clk_in);
    chk(p_rdata_out, 24'h123456);
    op(1, 16'h01ff, 1, 24'hfedcba);
    op(1, 16'h01ff, 0, 0);
    @(negedge clk_in);
    chk(p_rdata_out, 24'hfedcba);
    op(0, 16'h007e, 0, 0);
    chk(vec_fetch_out, 1);
    op(0, 16'h0080, 0, 0);
    chk(vec_fetch_out, 0);
    chk(illegal_fetch_out, 0);
  endtask
  task automatic t_rsv;
    op(0, 16'h3000, 0, 0);
    chk(illegal_fetch_out, 1);
    @(negedge clk_in);
    chk(p_rdata_out, 24'h000005);
    op(1, 16'h0200, 0, 0);
    @(negedge clk_in);
    chk(p_rdata_out, 24'h000005);
    op(2, 16'h2c00, 1, 24'hffffff);
    chk(periph_wr_out, 0);
    op(2, 16'h2c00, 0, 0);
    chk(periph_rd_out, 0);
    @(negedge clk_in);
    chk(x_rdata_out, 24'h000005);
    op(3, 16'h2700, 0, 0);
    @(negedge clk_in);
    chk(y_rdata_out, 24'h000005);
  endtask
  task automatic t_per;
    op(2, 16'hffff, 0, 0);
    chk(periph_rd_out, 1);
    chk(periph_slot_out, 5'h1f);
    @(negedge clk_in);
    chk(x_rdata_out, 24'h5aa51f);
    op(2, 16'hffe0, 1, 24'h0a0b0c);
    chk(periph_wr_out, 1);
    chk(periph_slot_out, 5'h00);
    chk(periph_wdata_out, 24'h0a0b0c);
    op(2, 16'hfffe, 1, 24'h777777);
    chk(periph_wr_out, 0);
    op(2, 16'hfffe, 0, 0);
    chk(periph_rd_out, 0);
    @(negedge clk_in);
    chk(x_rdata_out, 24'h000005);
  endtask
  task automatic t_ram;
    op(2, 16'h0010, 1, 24'habcdef);
    op(3, 16'h0010, 1, 24'h654321);
    op(2, 16'h0010, 0, 0);
    @(negedge clk_in);
    chk(x_rdata_out, 24'habcdef);
    op(3, 16'h0010, 0, 0);
    @(negedge clk_in);
    chk(y_rdata_out, 24'h654321);
  endtask
  // outside bootstrap the rom windows are ram; a mid-run reset brings the rom back over them
  task automatic t_reboot;
    op(1, 16'h0010, 1, 24'h222222);
    op(1, 16'h0010, 0, 0);
    @(negedge clk_in);
    chk(p_rdata_out, 24'h222222);
    boot_mode_sel_in = 3'h2;
    rst_in = 1'b1;
    @(negedge clk_in);
    chk(boot_mode_out, 0);
    rst_in = 1'b0;
    @(negedge clk_in);
    chk(boot_mode_out, 1);
    chk(boot_action_out, 3'h2);
    op(1, 16'h0010, 1, 24'h333333);
    op(1, 16'h0010, 0, 0);
    @(negedge clk_in);
    chk(p_rdata_out, 24'h3c3c10);
    boot_done_in = 1'b1;
    @(negedge clk_in);
    boot_done_in = 1'b0;
    op(1, 16'h0010, 0, 0);
    @(negedge clk_in);
    chk(p_rdata_out, 24'h222222);
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    {pab_in, xab_in, yab_in} = 48'h0;
    {p_wdata_in, x_wdata_in, y_wdata_in} = 72'h0;
    {p_fetch_in, p_rd_in, p_wr_in, x_rd_in, x_wr_in, y_rd_in, y_wr_in, boot_done_in} = 8'h00;
    boot_mode_sel_in = 3'h5;
    rst_in = 1'b1;
    repeat (12) @(negedge clk_in);
    chk(p_rdata_out, 0);
    chk(boot_mode_out, 0);
    rst_in = 1'b0;
    @(negedge clk_in);
    chk(boot_mode_out, 1);
    chk(boot_action_out, 3'h5);
    t_boot();
    t_rsv();
    t_per();
    t_ram();
    t_reboot();
    end_sim();
  end
endmodule
